// file: srst_pkg.sv
// Constants shared by the software reset control block.
package srst_pkg;

   // Register map.
   localparam logic [9:0] SOFTWARE_RESET_CONTROL_OFFSET = 10'h1f8;
   localparam logic [9:0] VPHY_MM_BASE = 10'h0a0;
   localparam logic [9:0] VPHY_MM_LAST = 10'h11c;
   localparam logic [31:0] SOFTWARE_RESET_CONTROL_RESET = 32'h0000_0000;

   // Field positions in the reset control word.
   localparam int DIGITAL_RST_BIT = 0;
   localparam int PORT_ONE_RST_BIT = 1;
   localparam int PORT_TWO_RST_BIT = 2;
   localparam int VIRTUAL_PHY_RESET_BIT_BIT = 3;

   // Timing.
   localparam int CLOCK_PERIOD_NS = 8;
   localparam int PHY_RESET_MIN_NS = 102000;
   localparam int PHY_RESET_CYCLES_DEFAULT = (PHY_RESET_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int DIGITAL_RESET_CYCLES = 16;
   localparam int DIG_CNT_W = 5;

   // Management addresses of the three PHYs.
   localparam logic [4:0] VPHY_MGMT_ADDR = 5'h00;
   localparam logic [4:0] PORT_ONE_MGMT_ADDR = 5'h01;
   localparam logic [4:0] PORT_TWO_MGMT_ADDR = 5'h02;

   // One-hot PHY select positions.
   localparam int SEL_VPHY = 0;
   localparam int SEL_PORT_ONE = 1;
   localparam int SEL_PORT_TWO = 2;

   // Read data for an address that no PHY answers.
   localparam logic [15:0] MGMT_IDLE_DATA = 16'hffff;

   // Digital reset sequence.
   typedef enum logic [2:0] {
      DIG_IDLE = 3'b001,
      DIG_HOLD = 3'b010,
      DIG_DONE = 3'b100
   } srst_dig_state_t;

endpackage

// file: srst_reset_timer.sv
// Reset pulse stretcher that holds its output for a fixed number of cycles.
`timescale 1ns/100ps
module srst_reset_timer
   import srst_pkg::*;
#(
   parameter int CYCLES = 1
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_sync_b,
   // Control.
   input wire logic start,
   // Status.
   output logic hold,
   output logic done
);

   localparam int W = $clog2(CYCLES + 1);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic hold;
   } srst_timer_state_t;

   srst_timer_state_t r;
   srst_timer_state_t n;

   always_comb begin
      n = r;
      if (r.hold) begin
         if (r.cnt == W'(CYCLES - 1)) begin
            n.hold = 1'b0;
            n.cnt = '0;
         end else begin
            n.cnt = r.cnt + W'(1);
         end
      end else if (start) begin
         n.hold = 1'b1;
         n.cnt = '0;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign hold = r.hold;
   // Done marks the last held cycle, so the owner clears its bit at the edge that ends the hold.
   assign done = r.hold & (r.cnt == W'(CYCLES - 1));

endmodule

// file: srst_mgmt_router.sv
// Routes clause-22 management requests to the PHY at the matching address.
`timescale 1ns/100ps
module srst_mgmt_router
   import srst_pkg::*;
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_sync_b,
   // Request.
   input wire logic req,
   input wire logic req_tag,
   input wire logic req_wr,
   input wire logic [4:0] req_phy_addr,
   input wire logic [4:0] req_reg_idx,
   input wire logic [15:0] req_wdata,
   // PHY register ports.
   output logic [2:0] phy_sel,
   output logic phy_wr,
   output logic [4:0] phy_idx,
   output logic [15:0] phy_wdata,
   input wire logic [15:0] port_one_rdata,
   input wire logic [15:0] port_two_rdata,
   input wire logic [15:0] vphy_rdata,
   // Answer.
   output logic ack,
   output logic ack_tag,
   output logic [15:0] rdata
);

   typedef struct packed {
      logic [2:0] sel;
      logic wr;
      logic [4:0] idx;
      logic [15:0] wdata;
      logic pend;
      logic pend_tag;
      logic ack;
      logic ack_tag;
      logic [15:0] rdata;
   } srst_router_state_t;

   srst_router_state_t r;
   srst_router_state_t n;

   always_comb begin
      n = r;
      n.ack = r.pend;
      n.ack_tag = r.pend_tag;
      n.rdata = MGMT_IDLE_DATA;
      unique case (1'b1)
         r.sel[SEL_VPHY]: n.rdata = vphy_rdata;
         r.sel[SEL_PORT_ONE]: n.rdata = port_one_rdata;
         r.sel[SEL_PORT_TWO]: n.rdata = port_two_rdata;
         default: n.rdata = MGMT_IDLE_DATA;
      endcase
      n.pend = req;
      n.pend_tag = req_tag;
      n.wr = req & req_wr;
      n.idx = req_reg_idx;
      n.wdata = req_wdata;
      n.sel = 3'h0;
      if (req) begin
         n.sel[SEL_VPHY] = (req_phy_addr == VPHY_MGMT_ADDR);
         n.sel[SEL_PORT_ONE] = (req_phy_addr == PORT_ONE_MGMT_ADDR);
         n.sel[SEL_PORT_TWO] = (req_phy_addr == PORT_TWO_MGMT_ADDR);
      end
   end

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign phy_sel = r.sel;
   assign phy_wr = r.wr;
   assign phy_idx = r.idx;
   assign phy_wdata = r.wdata;
   assign ack = r.ack;
   assign ack_tag = r.ack_tag;
   assign rdata = r.rdata;

endmodule

// file: srst_reset_control.sv
// Software reset control register with PHY reset timing and management routing.
`timescale 1ns/100ps
module srst_reset_control
   import srst_pkg::*;
#(
   parameter int PHY_RESET_CYCLES = PHY_RESET_CYCLES_DEFAULT
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_b,
   // Host register access.
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [9:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_from_eeprom,
   input wire logic extended_serial_management_mode,
   input wire logic reg_half_hi,
   output logic reg_ack,
   output logic [31:0] reg_rdata,
   output logic reg_rdata_valid,
   // Serial management of the PHYs.
   input wire logic mgmt_req,
   input wire logic mgmt_wr,
   input wire logic [4:0] mgmt_phy_addr,
   input wire logic [4:0] mgmt_reg_idx,
   input wire logic [15:0] mgmt_wdata,
   output logic mgmt_ready,
   output logic mgmt_ack,
   output logic [15:0] mgmt_rdata,
   // PHY register ports.
   output logic [2:0] phy_sel,
   output logic phy_wr,
   output logic [4:0] phy_idx,
   output logic [15:0] phy_wdata,
   input wire logic [15:0] port_one_rdata,
   input wire logic [15:0] port_two_rdata,
   input wire logic [15:0] vphy_rdata,
   // Reset outputs and status.
   input wire logic vphy_in_reset,
   output logic port_one_phy_reset,
   output logic port_two_phy_reset,
   output logic vphy_reset,
   output logic chip_soft_reset,
   output logic eeprom_abort,
   output logic eeprom_reload
);

   typedef struct packed {
      logic virtual_phy_reset_bit;
      logic vphy_seen;
      logic port_one_phy_reset_bit;
      logic port_two_phy_reset_bit;
      logic digital_reset_bit;
      srst_dig_state_t dig_state;
      logic [DIG_CNT_W-1:0] dig_cnt;
      logic abort;
      logic reload;
      logic ack;
      logic [31:0] rdata;
      logic valid;
   } srst_ctl_state_t;

   // Reset image of the whole state; every bit starts clear except dig_state, which starts in DIG_IDLE.
   localparam srst_ctl_state_t CTL_RESET = '{
      virtual_phy_reset_bit: 1'b0,
      vphy_seen: 1'b0,
      port_one_phy_reset_bit: 1'b0,
      port_two_phy_reset_bit: 1'b0,
      digital_reset_bit: 1'b0,
      dig_state: DIG_IDLE,
      dig_cnt: '0,
      abort: 1'b0,
      reload: 1'b0,
      ack: 1'b0,
      rdata: SOFTWARE_RESET_CONTROL_RESET,
      valid: 1'b0
   };

   srst_ctl_state_t r;
   srst_ctl_state_t n;

   logic rst_meta_b_r;
   logic rst_sync_b_r;

   logic ctl_hit;
   logic host_wr;
   logic vphy_hit;
   logic mm_req;
   logic [4:0] mm_idx;
   logic vphy_accept;
   logic dig_accept;
   logic [1:0] phy_start;
   logic [1:0] phy_hold;
   logic [1:0] phy_done;
   logic [1:0] phy_bits;
   logic [31:0] ctl_word;
   logic [31:0] ctl_read;
   logic rt_req;
   logic rt_tag;
   logic rt_wr;
   logic [4:0] rt_phy_addr;
   logic [4:0] rt_reg_idx;
   logic [15:0] rt_wdata;
   logic rt_ack;
   logic rt_ack_tag;
   logic [15:0] rt_rdata;
   logic reg_local;
   logic ans_valid;
   logic dig_last;

   // The reset is released through two flops so no flop sees a ragged release.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_b_r <= 1'b0;
         rst_sync_b_r <= 1'b0;
      end else begin
         rst_meta_b_r <= 1'b1;
         rst_sync_b_r <= rst_meta_b_r;
      end
   end

   // Address decode.
   assign ctl_hit = (reg_addr == SOFTWARE_RESET_CONTROL_OFFSET);
   assign vphy_hit = (reg_addr >= VPHY_MM_BASE) && (reg_addr <= VPHY_MM_LAST);
   // Loader writes are still answered but change no bit.
   assign host_wr = reg_wr & ctl_hit & ~reg_from_eeprom;
   // Window words are four bytes apart, so the two low address bits are dropped.
   assign mm_idx = 5'((reg_addr - VPHY_MM_BASE) >> 2);

   // A write of one is taken only while the bit is clear.
   assign vphy_accept = host_wr & reg_wdata[VIRTUAL_PHY_RESET_BIT_BIT] & ~r.virtual_phy_reset_bit;
   // The digital bit stays set through the whole sequence, so a second start cannot slip in.
   assign dig_accept = host_wr & reg_wdata[DIGITAL_RST_BIT] & ~r.digital_reset_bit;
   assign phy_bits = {r.port_two_phy_reset_bit, r.port_one_phy_reset_bit};

   // A write that sets several bits starts each of them at the same edge.
   for (genvar p = 0; p < 2; p++) begin : g_phy_start
      assign phy_start[p] = host_wr & reg_wdata[PORT_ONE_RST_BIT + p] & ~phy_bits[p];
   end

   // Each port PHY has its own hold timer.
   for (genvar g = 0; g < 2; g++) begin : g_phy_timer
      srst_reset_timer #(
         .CYCLES(PHY_RESET_CYCLES)
      ) u_timer (
         .clock(clock),
         .rst_sync_b(rst_sync_b_r),
         .start(phy_start[g]),
         .hold(phy_hold[g]),
         .done(phy_done[g])
      );
   end

   // Memory-mapped virtual PHY access shares the router with the serial port.
   assign mm_req = (reg_rd | reg_wr) & vphy_hit;
   // A serial request that meets a window access is dropped, not queued.
   assign mgmt_ready = ~mm_req;
   assign rt_req = mm_req | mgmt_req;
   // The tag steers the answer back to whichever port asked.
   assign rt_tag = mm_req;
   always_comb begin
      if (mm_req) begin
         rt_wr = reg_wr;
         rt_phy_addr = VPHY_MGMT_ADDR;
         rt_reg_idx = mm_idx;
         rt_wdata = reg_wdata[15:0];
      end else begin
         rt_wr = mgmt_wr;
         rt_phy_addr = mgmt_phy_addr;
         rt_reg_idx = mgmt_reg_idx;
         rt_wdata = mgmt_wdata;
      end
   end

   srst_mgmt_router u_router (
      .clock(clock),
      .rst_sync_b(rst_sync_b_r),
      .req(rt_req),
      .req_tag(rt_tag),
      .req_wr(rt_wr),
      .req_phy_addr(rt_phy_addr),
      .req_reg_idx(rt_reg_idx),
      .req_wdata(rt_wdata),
      .phy_sel(phy_sel),
      .phy_wr(phy_wr),
      .phy_idx(phy_idx),
      .phy_wdata(phy_wdata),
      .port_one_rdata(port_one_rdata),
      .port_two_rdata(port_two_rdata),
      .vphy_rdata(vphy_rdata),
      .ack(rt_ack),
      .ack_tag(rt_ack_tag),
      .rdata(rt_rdata)
   );

   // Reserved bits read as zero.
   always_comb begin
      ctl_word = 32'h0000_0000;
      ctl_word[DIGITAL_RST_BIT] = r.digital_reset_bit;
      ctl_word[PORT_ONE_RST_BIT] = r.port_one_phy_reset_bit;
      ctl_word[PORT_TWO_RST_BIT] = r.port_two_phy_reset_bit;
      ctl_word[VIRTUAL_PHY_RESET_BIT_BIT] = r.virtual_phy_reset_bit;
   end

   // Either half can be fetched alone; no pairing latch is kept.
   always_comb begin
      if (extended_serial_management_mode & reg_half_hi) begin
         ctl_read = {16'h0000, ctl_word[31:16]};
      end else begin
         ctl_read = ctl_word;
      end
   end

   // Register accesses outside the window are answered by this block itself.
   assign reg_local = (reg_rd | reg_wr) & ~vphy_hit;
   // Data fetched while the chip is held in digital reset is flagged, not withheld.
   assign ans_valid = (r.dig_state != DIG_HOLD);
   assign dig_last = (r.dig_cnt == DIG_CNT_W'(DIGITAL_RESET_CYCLES - 1));

   always_comb begin
      n = r;
      n.abort = 1'b0;
      n.reload = 1'b0;

      // Register read answers, never gated by device readiness.
      n.ack = 1'b0;
      n.valid = 1'b0;
      if (reg_local) begin
         n.ack = 1'b1;
         n.rdata = (reg_rd & ctl_hit) ? ctl_read : 32'h0000_0000;
         n.valid = ans_valid;
      // Window answers come back through the router two edges after the request.
      end else if (rt_ack & rt_ack_tag) begin
         n.ack = 1'b1;
         n.rdata = {16'h0000, rt_rdata};
         n.valid = ans_valid;
      end

      // Virtual PHY: hold reset until it reports reset, then wait for release.
      if (vphy_accept) begin
         n.virtual_phy_reset_bit = 1'b1;
         n.vphy_seen = 1'b0;
      end else if (r.virtual_phy_reset_bit) begin
         if (vphy_in_reset) begin
            n.vphy_seen = 1'b1;
         end else if (r.vphy_seen) begin
            n.virtual_phy_reset_bit = 1'b0;
            n.vphy_seen = 1'b0;
         end
      end

      // Port PHY bits follow their timers.
      if (phy_start[0]) begin
         n.port_one_phy_reset_bit = 1'b1;
      end else if (phy_done[0]) begin
         n.port_one_phy_reset_bit = 1'b0;
      end

      // The two timers run apart, so both ports may be in reset at once.
      if (phy_start[1]) begin
         n.port_two_phy_reset_bit = 1'b1;
      end else if (phy_done[1]) begin
         n.port_two_phy_reset_bit = 1'b0;
      end

      // Digital reset sequence; the PHY bits and timers are not touched.
      unique case (r.dig_state)
         DIG_IDLE: begin
            if (dig_accept) begin
               n.digital_reset_bit = 1'b1;
               n.dig_state = DIG_HOLD;
               n.dig_cnt = '0;
               // The loader is told to stop at the same edge the hold begins.
               n.abort = 1'b1;
            end
         end
         DIG_HOLD: begin
            if (dig_last) begin
               n.dig_state = DIG_DONE;
            end else begin
               n.dig_cnt = r.dig_cnt + DIG_CNT_W'(1);
            end
         end
         DIG_DONE: begin
            // The bit drops and the reload starts once the hold has ended.
            n.digital_reset_bit = 1'b0;
            n.reload = 1'b1;
            n.dig_state = DIG_IDLE;
         end
         default: begin
            n.dig_state = DIG_IDLE;
            n.digital_reset_bit = 1'b0;
         end
      endcase
   end

   // This block sits outside its own digital reset; only the pin reset clears it.
   always_ff @(posedge clock or negedge rst_sync_b_r) begin
      if (!rst_sync_b_r) begin
         r <= CTL_RESET;
      end else begin
         r <= n;
      end
   end

   // Outputs.
   assign reg_ack = r.ack;
   assign reg_rdata = r.rdata;
   assign reg_rdata_valid = r.valid;
   // Serial answers are the router answers not tagged as window traffic.
   assign mgmt_ack = rt_ack & ~rt_ack_tag;
   assign mgmt_rdata = rt_rdata;
   assign port_one_phy_reset = phy_hold[0];
   assign port_two_phy_reset = phy_hold[1];
   assign vphy_reset = r.virtual_phy_reset_bit & ~r.vphy_seen;
   // Downstream CSRs clear on this level; survives_soft_reset_type bits ignore it.
   assign chip_soft_reset = r.dig_state[1];
   assign eeprom_abort = r.abort;
   assign eeprom_reload = r.reload;

endmodule

// file: srst_phy_model.sv
// Behavioural model of the three PHYs behind the reset control block.
`timescale 1ns/100ps
module srst_phy_model (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_b,
   // Register port.
   input wire logic [2:0] phy_sel,
   input wire logic [4:0] phy_idx,
   output logic [15:0] port_one_rdata,
   output logic [15:0] port_two_rdata,
   output logic [15:0] vphy_rdata,
   // Virtual PHY reset.
   input wire logic vphy_reset,
   output logic vphy_in_reset
);
   logic [1:0] tail_r;
   // An unselected PHY shows the inverse, so a read from the wrong PHY cannot pass.
   assign vphy_rdata = {8'h33, 3'h0, phy_idx} ^ {16{!phy_sel[0]}};
   assign port_one_rdata = {8'h11, 3'h0, phy_idx} ^ {16{!phy_sel[1]}};
   assign port_two_rdata = {8'h22, 3'h0, phy_idx} ^ {16{!phy_sel[2]}};
   // The PHY stays in reset a few cycles after the request drops.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         vphy_in_reset <= 1'b0;
         tail_r <= 2'h0;
      end else begin
         vphy_in_reset <= vphy_reset || tail_r != 2'h0;
         if (vphy_reset)
            tail_r <= 2'h3;
         else if (tail_r != 2'h0)
            tail_r <= tail_r - 2'h1;
      end
   end
endmodule

// file: srst_monitor.sv
// Checker watching the ports of the reset control block.
`timescale 1ns/100ps
module srst_monitor
   import srst_pkg::*;
#(
   parameter int PHY_RESET_CYCLES = 20
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_b,
   // Register bus.
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [9:0] reg_addr,
   input wire logic reg_from_eeprom,
   input wire logic reg_ack,
   input wire logic reg_rdata_valid,
   // Management.
   input wire logic mgmt_req,
   input wire logic mgmt_ready,
   input wire logic [4:0] mgmt_phy_addr,
   input wire logic mgmt_ack,
   input wire logic [15:0] mgmt_rdata,
   input wire logic [2:0] phy_sel,
   // Resets.
   input wire logic vphy_in_reset,
   input wire logic port_one_phy_reset,
   input wire logic port_two_phy_reset,
   input wire logic vphy_reset,
   input wire logic chip_soft_reset,
   input wire logic eeprom_abort,
   input wire logic eeprom_reload
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   logic hit;
   logic any_phy;
   logic [15:0] len_one_r;
   logic [15:0] len_two_r;
   assign hit = reg_wr && reg_addr == SOFTWARE_RESET_CONTROL_OFFSET;
   assign any_phy = port_one_phy_reset || port_two_phy_reset || vphy_reset;
   // Hold lengths are counted here because a repetition cannot span them.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         len_one_r <= 16'h0;
         len_two_r <= 16'h0;
      end else begin
         len_one_r <= port_one_phy_reset ? len_one_r + 16'h1 : 16'h0;
         len_two_r <= port_two_phy_reset ? len_two_r + 16'h1 : 16'h0;
      end
   end
   a_loader_locked: assert property (hit && reg_from_eeprom && !port_one_phy_reset |=> !port_one_phy_reset)
      else $error("loader write started a port reset");
   a_one_hold: assert property ($fell(port_one_phy_reset) |-> len_one_r >= PHY_RESET_CYCLES)
      else $error("port one reset too short");
   a_two_hold: assert property ($fell(port_two_phy_reset) |-> len_two_r >= PHY_RESET_CYCLES)
      else $error("port two reset too short");
   a_vphy_release: assert property (vphy_reset && vphy_in_reset |=> !vphy_reset)
      else $error("virtual PHY reset not released");
   a_dig_abort: assert property ($rose(chip_soft_reset) |-> eeprom_abort)
      else $error("loader command not aborted");
   a_dig_reload: assert property ($rose(chip_soft_reset) |->
      chip_soft_reset[*8] ##1 chip_soft_reset[*8] ##1 !chip_soft_reset ##1 eeprom_reload)
      else $error("digital reset length or reload wrong");
   a_dig_spares_phys: assert property ($rose(chip_soft_reset) && !any_phy |-> (!any_phy)[*8])
      else $error("digital reset touched a PHY");
   a_rd_invalid: assert property (reg_ack && chip_soft_reset && $past(chip_soft_reset) |-> !reg_rdata_valid)
      else $error("read during reset marked valid");
   a_reg_ack: assert property ((reg_rd || reg_wr) && reg_addr == SOFTWARE_RESET_CONTROL_OFFSET |=> reg_ack)
      else $error("register access not answered");
   a_mgmt_ack: assert property (mgmt_req && mgmt_ready |-> ##2 mgmt_ack)
      else $error("management request not answered");
   a_no_phy: assert property (mgmt_req && mgmt_ready && mgmt_phy_addr > 5'h2 |=>
      phy_sel == 3'h0 ##1 mgmt_rdata == MGMT_IDLE_DATA)
      else $error("unknown PHY address answered");
   c_port_reset: cover property ($fell(port_one_phy_reset));
   c_dig_reset: cover property ($fell(chip_soft_reset));
   c_mgmt: cover property (mgmt_ack);
endmodule

// file: tb_top.sv
// Self-checking bench for the software reset control block.
`timescale 1ns/100ps
module tb_top;
   import srst_pkg::*;
   localparam int PRC = 20;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic reg_rd = 1'b0;
   logic reg_wr = 1'b0;
   logic [9:0] reg_addr = 10'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_from_eeprom = 1'b0;
   logic extended_serial_management_mode = 1'b0;
   logic reg_half_hi = 1'b0;
   logic mgmt_req = 1'b0;
   logic mgmt_wr = 1'b0;
   logic [4:0] mgmt_phy_addr = 5'h0;
   logic [4:0] mgmt_reg_idx = 5'h0;
   logic [15:0] mgmt_wdata = 16'h0;
   logic reg_ack, reg_rdata_valid, mgmt_ready, mgmt_ack, phy_wr, vphy_in_reset, vphy_reset;
   logic port_one_phy_reset, port_two_phy_reset, chip_soft_reset, eeprom_abort, eeprom_reload;
   logic [31:0] reg_rdata;
   logic [15:0] mgmt_rdata, phy_wdata, port_one_rdata, port_two_rdata, vphy_rdata;
   logic [2:0] phy_sel;
   logic [4:0] phy_idx;
   logic [31:0] seed = 32'h59;
   logic [31:0] q;
   logic vld;
   logic [19:0] ps;
   int failures = 0;
   int n_checks = 0;
   int cyc = 0;
   always #4 clock = !clock;
   srst_reset_control #(.PHY_RESET_CYCLES(PRC)) uut (.clock, .rst_b, .reg_rd, .reg_wr, .reg_addr,
      .reg_wdata, .reg_from_eeprom, .extended_serial_management_mode, .reg_half_hi, .reg_ack,
      .reg_rdata, .reg_rdata_valid, .mgmt_req, .mgmt_wr, .mgmt_phy_addr, .mgmt_reg_idx, .mgmt_wdata,
      .mgmt_ready, .mgmt_ack, .mgmt_rdata, .phy_sel, .phy_wr, .phy_idx, .phy_wdata, .port_one_rdata,
      .port_two_rdata, .vphy_rdata, .vphy_in_reset, .port_one_phy_reset, .port_two_phy_reset,
      .vphy_reset, .chip_soft_reset, .eeprom_abort, .eeprom_reload);
   srst_phy_model phy (.clock, .rst_b, .phy_sel, .phy_idx, .port_one_rdata, .port_two_rdata,
      .vphy_rdata, .vphy_reset, .vphy_in_reset);
   function automatic void step();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
   endfunction
   function automatic logic [15:0] phy_exp(input logic [4:0] a, input logic [4:0] i);
      case (a)
         VPHY_MGMT_ADDR: return {8'h33, 3'h0, i};
         PORT_ONE_MGMT_ADDR: return {8'h11, 3'h0, i};
         PORT_TWO_MGMT_ADDR: return {8'h22, 3'h0, i};
         default: return MGMT_IDLE_DATA;
      endcase
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // The bus and mgmt tasks are entered just after an edge and leave just after the answer edge.
   task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
      int i;
      // One edge passes first, so a strobe is never dropped and raised in one step.
      @(posedge clock);
      #1;
      reg_wr = wr;
      reg_rd = !wr;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clock);
      #1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      for (i = 0; i < 4 && reg_ack !== 1'b1; i++) begin
         @(posedge clock);
         #1;
      end
      q = reg_ack ? reg_rdata : 32'hx;
      vld = reg_rdata_valid;
   endtask
   task automatic mgmt(input logic [4:0] a, input logic [4:0] i, input logic wr);
      int k;
      @(posedge clock);
      #1;
      mgmt_req = 1'b1;
      mgmt_wr = wr;
      mgmt_phy_addr = a;
      mgmt_reg_idx = i;
      mgmt_wdata = seed[31:16];
      @(posedge clock);
      #1;
      mgmt_req = 1'b0;
      ps = {phy_wr, phy_sel, phy_wdata};
      for (k = 0; k < 4 && mgmt_ack !== 1'b1; k++) begin
         @(posedge clock);
         #1;
      end
      q = mgmt_ack ? {16'h0, mgmt_rdata} : 32'hx;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         finish_test();
      end
   end
   initial begin
      int b;
      int k;
      logic [4:0] a;
      logic w;
      longint t0;
      repeat (16) @(posedge clock);
      #1;
      rst_b = 1'b1;
      // Only the reset register is touched until the chip has settled.
      repeat (4) @(posedge clock);
      #1;
      bus(1'b0, SOFTWARE_RESET_CONTROL_OFFSET, 32'h0);
      chk(q, SOFTWARE_RESET_CONTROL_RESET);
      reg_from_eeprom = 1'b1;
      bus(1'b1, SOFTWARE_RESET_CONTROL_OFFSET, 32'hf);
      reg_from_eeprom = 1'b0;
      bus(1'b0, SOFTWARE_RESET_CONTROL_OFFSET, 32'h0);
      chk(q, 32'h0);
      chk({port_one_phy_reset, port_two_phy_reset, vphy_reset, chip_soft_reset}, 4'h0);
      for (b = 1; b < 3; b++) begin
         bus(1'b1, SOFTWARE_RESET_CONTROL_OFFSET, 32'h1 << b);
         t0 = $time;
         chk(b == 1 ? port_one_phy_reset : port_two_phy_reset, 1'b1);
         bus(1'b1, SOFTWARE_RESET_CONTROL_OFFSET, 32'h1 << b);
         extended_serial_management_mode = 1'b1;
         reg_half_hi = 1'b1;
         bus(1'b0, SOFTWARE_RESET_CONTROL_OFFSET, 32'h0);
         chk(q, 32'h0);
         reg_half_hi = 1'b0;
         bus(1'b0, SOFTWARE_RESET_CONTROL_OFFSET, 32'h0);
         chk(q, 32'h1 << b);
         extended_serial_management_mode = 1'b0;
         for (k = 0; k < 40 && (b == 1 ? port_one_phy_reset : port_two_phy_reset); k++) begin
            @(posedge clock);
            #1;
         end
         // A rewrite while set must not restart the hold.
         chk(32'(($time - t0) / 8), 32'(PRC));
         bus(1'b0, SOFTWARE_RESET_CONTROL_OFFSET, 32'h0);
         chk(q, 32'h0);
      end
      bus(1'b1, SOFTWARE_RESET_CONTROL_OFFSET, 32'h8);
      chk(vphy_reset, 1'b1);
      k = 0;
      do begin
         bus(1'b0, SOFTWARE_RESET_CONTROL_OFFSET, 32'h0);
         k++;
      end while (q !== 32'h0 && k < 20);
      chk(q, 32'h0);
      bus(1'b1, SOFTWARE_RESET_CONTROL_OFFSET, 32'h1);
      chk({chip_soft_reset, eeprom_abort}, 2'h3);
      bus(1'b0, SOFTWARE_RESET_CONTROL_OFFSET, 32'h0);
      chk(vld, 1'b0);
      chk({port_one_phy_reset, port_two_phy_reset, vphy_reset}, 3'h0);
      for (k = 0; k < 30 && eeprom_reload !== 1'b1; k++) begin
         @(posedge clock);
         #1;
      end
      chk(eeprom_reload, 1'b1);
      bus(1'b0, SOFTWARE_RESET_CONTROL_OFFSET, 32'h0);
      chk(q, 32'h0);
      chk(vld, 1'b1);
      for (k = 0; k < 16; k++) begin
         step();
         bus(1'b0, VPHY_MM_BASE + {3'h0, seed[6:2], 2'h0}, 32'h0);
         chk(q, {16'h0, phy_exp(VPHY_MGMT_ADDR, seed[6:2])});
         a = (k == 0) ? 5'h1f : {3'h0, seed[9:8]};
         w = seed[15] && k > 1;
         mgmt(a, seed[14:10], w);
         chk(ps, {w, (a < 5'h3) ? 3'(1 << a) : 3'h0, seed[31:16]});
         if (!w)
            chk(q, {16'h0, phy_exp(a, seed[14:10])});
      end
      finish_test();
   end
endmodule
bind srst_reset_control srst_monitor #(.PHY_RESET_CYCLES(PHY_RESET_CYCLES)) mon (.clock, .rst_b, .reg_rd,
   .reg_wr, .reg_addr, .reg_from_eeprom, .reg_ack, .reg_rdata_valid, .mgmt_req, .mgmt_ready,
   .mgmt_phy_addr, .mgmt_ack, .mgmt_rdata, .phy_sel, .vphy_in_reset, .port_one_phy_reset,
   .port_two_phy_reset, .vphy_reset, .chip_soft_reset, .eeprom_abort, .eeprom_reload);
